// File: irqcmd_top.sv
// Interrupt-control and error-flag command interpreter with APB registers
// What this block does
// - Code 36 clears error flags chosen by the type byte only.
// - Clear with type 0 resets every error flag at once.
// - Clear types 1 to 5 reset timeout, alarm, deviation, position, shutdown.
// - Code 25 enables the single interrupt named by the type byte.
// - Enable with number 255 sets the global interrupt enable.
// - Code 26 disables the single interrupt named by the type byte.
// - Disable with number 255 clears the global interrupt enable.
// - Code 37 stores the value field as handler address of an interrupt.
// - A later handler address replaces the earlier one.
// - Handler address set and return act only from the stored program.
// - Code 38 restores saved accumulator, X, flags and program counter.
// - Codes 64 to 71 are eight user function slots.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irqcmd_map.svh"
module irqcmd_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic prog_valid,
	input wire irqcmd_pkg::irqcmd_cmd_t prog_cmd,
	output logic prog_ready,
	input wire logic ctx_save,
	input wire irqcmd_pkg::irqcmd_ctx_t ctx_in,
	output logic ctx_restore,
	output irqcmd_pkg::irqcmd_ctx_t ctx_out,
	input wire logic [4:0] err_pin,
	output logic [4:0] err_flags,
	output logic [15:0] irq_enable,
	output logic irq_global,
	input wire logic [3:0] vec_rd_idx,
	output logic [31:0] vec_rd_data,
	output logic uf_start,
	output logic [2:0] uf_slot,
	output irqcmd_pkg::irqcmd_cmd_t uf_cmd,
	input wire logic [31:0] uf_reply,
	output logic irq
);
	logic [31:0] head;
	logic [31:0] value;
	logic host_pend;
	logic csum_ok;
	logic [7:0] reply_st;
	logic [31:0] reply_val;
	logic [3:0] evt;
	logic [3:0] mask;
	logic [4:0] err_s1;
	logic [4:0] err_s2;
	logic vec_we;
	logic [3:0] vec_waddr;
	logic [31:0] vec_wdata;
	irqcmd_pkg::irqcmd_ctx_t saved;
	logic setup;
	logic wr_acc;
	logic rd_evt;
	logic wr_check;
	logic [7:0] sum;
	logic ex_valid;
	logic ex_host;
	logic ex_ok;
	irqcmd_pkg::irqcmd_cmd_t ex;
	logic is_uf;
	logic idx_ok;
	logic [4:0] next_err;
	logic [3:0] evt_set;
	logic [7:0] next_st;
	logic [31:0] next_rval;

	// APB phases; the slave answers in the first access cycle
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign wr_check = wr_acc && (paddr == `IRQCMD_OFS_CHECK);
	assign rd_evt = psel && penable && !pwrite
		&& (paddr == `IRQCMD_OFS_EVT);

	// Modulo-256 sum of the first eight frame bytes
	assign sum = 8'(head[31:24] + head[23:16] + head[15:8] + head[7:0]
		+ value[31:24] + value[23:16] + value[15:8] + value[7:0]);

	// Host frame words, written before the checksum word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			head <= `IRQCMD_ZERO32;
			value <= `IRQCMD_ZERO32;
		end else if (wr_acc && paddr == `IRQCMD_OFS_HEAD) begin
			head <= pwdata;
		end else if (wr_acc && paddr == `IRQCMD_OFS_VALUE) begin
			value <= pwdata;
		end
	end

	// Checksum write launches the host frame next cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_pend <= 1'b0;
			csum_ok <= 1'b0;
			prog_ready <= 1'b0;
		end else begin
			host_pend <= wr_check;
			csum_ok <= (sum == pwdata[7:0]);
			prog_ready <= !wr_check; // Host frame owns that slot
		end
	end

	// Pick the frame to run; a host frame always has the slot to itself
	always_comb begin
		ex_host = host_pend;
		ex_valid = host_pend || (prog_valid && prog_ready);
		ex = prog_cmd;
		ex_ok = 1'b1;
		if (host_pend) begin
			ex.instr = head[23:16];
			ex.typ = head[15:8];
			ex.bank = head[7:0];
			ex.value = value;
			ex_ok = csum_ok;
		end
	end

	assign is_uf = ex.instr >= `IRQCMD_OP_UF_LO
		&& ex.instr <= `IRQCMD_OP_UF_HI;
	assign idx_ok = ex.typ < 8'(`IRQCMD_NIRQ);

	// Error flags: a raised pin wins over a clear in the same cycle
	always_comb begin
		next_err = err_flags;
		if (ex_valid && ex_ok && ex.instr == `IRQCMD_OP_CLEAR) begin
			if (ex.typ == `IRQCMD_TYPE_ALL) begin
				next_err = '0;
			end else if (ex.typ <= 8'(`IRQCMD_NERR)) begin
				next_err[3'(ex.typ - 8'h01)] = 1'b0;
			end
		end
		next_err = next_err | err_s2;
	end

	// Pin synchroniser, then the sticky flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_s1 <= '0;
			err_s2 <= '0;
			err_flags <= '0;
		end else begin
			err_s1 <= err_pin;
			err_s2 <= err_s1;
			err_flags <= next_err;
		end
	end

	// Per-source and global interrupt enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable <= '0;
			irq_global <= 1'b0;
		end else if (ex_valid && ex_ok) begin
			if (ex.instr == `IRQCMD_OP_UNMASK) begin
				if (ex.typ == `IRQCMD_TYPE_GLOBAL) begin
					irq_global <= 1'b1;
				end else if (idx_ok) begin
					irq_enable[ex.typ[3:0]] <= 1'b1;
				end
			end else if (ex.instr == `IRQCMD_OP_MASKOFF) begin
				if (ex.typ == `IRQCMD_TYPE_GLOBAL) begin
					irq_global <= 1'b0;
				end else if (idx_ok) begin
					irq_enable[ex.typ[3:0]] <= 1'b0;
				end
			end
		end
	end

	// Handler address writes come only from the stored program
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_we <= 1'b0;
			vec_waddr <= '0;
			vec_wdata <= `IRQCMD_ZERO32;
		end else begin
			vec_we <= ex_valid && !ex_host && idx_ok
				&& ex.instr == `IRQCMD_OP_VECSET;
			vec_waddr <= ex.typ[3:0];
			vec_wdata <= ex.value;
		end
	end

	// Table slot is simply rewritten, so redefinition is free
	irqcmd_vec_mem #(
		.DEPTH(`IRQCMD_NIRQ),
		.AW(4),
		.DW(32)
	) irqcmd_vec_mem_i (
		.clk(pclk),
		.we(vec_we),
		.waddr(vec_waddr),
		.wdata(vec_wdata),
		.raddr(vec_rd_idx),
		.rdata(vec_rd_data)
	);

	// Context saved on handler entry, handed back on return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saved <= '0;
			ctx_out <= '0;
			ctx_restore <= 1'b0;
		end else begin
			if (ctx_save) begin
				saved <= ctx_in;
			end
			ctx_restore <= ex_valid && !ex_host
				&& ex.instr == `IRQCMD_OP_RETURN;
			ctx_out <= saved;
		end
	end

	// User function slots hand the whole frame to outside logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uf_start <= 1'b0;
			uf_slot <= '0;
			uf_cmd <= '0;
		end else begin
			uf_start <= ex_valid && ex_ok && is_uf;
			uf_slot <= ex.instr[2:0];
			uf_cmd <= ex;
		end
	end

	// Reply status; a refused program-only code changes nothing else
	always_comb begin
		next_st = `IRQCMD_ST_OK;
		next_rval = `IRQCMD_ZERO32;
		evt_set = '0;
		if (!ex_ok) begin
			next_st = `IRQCMD_ST_CSUM;
			evt_set[`IRQCMD_EVT_CSUM] = 1'b1;
		end else if (is_uf) begin
			next_rval = uf_reply;
		end else if (ex.instr == `IRQCMD_OP_VECSET
			|| ex.instr == `IRQCMD_OP_RETURN) begin
			if (ex_host) begin
				next_st = `IRQCMD_ST_REFUSED;
				evt_set[`IRQCMD_EVT_REFUSE] = 1'b1;
			end
		end else if (ex.instr == `IRQCMD_OP_CLEAR) begin
			if (ex.typ > 8'(`IRQCMD_NERR)) begin
				next_st = `IRQCMD_ST_BADTYPE;
			end
		end else if (ex.instr != `IRQCMD_OP_UNMASK
			&& ex.instr != `IRQCMD_OP_MASKOFF) begin
			next_st = `IRQCMD_ST_BADCMD;
		end
		evt_set[`IRQCMD_EVT_DONE] = ex_valid;
		if (!ex_valid) begin
			evt_set = '0;
		end
		evt_set[`IRQCMD_EVT_ERR] = |(err_s2 & ~err_flags);
	end

	// Reply registers track the latest executed frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reply_st <= '0;
			reply_val <= `IRQCMD_ZERO32;
		end else if (ex_valid) begin
			reply_st <= next_st;
			reply_val <= next_rval;
		end
	end

	// Sticky events; a read clears only the bits it reported, so an
	// event landing at the setup edge is not lost, and a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt <= '0;
		end else begin
			evt <= (rd_evt ? evt & ~prdata[3:0] : evt) | evt_set;
		end
	end

	// Mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= '0;
		end else if (wr_acc && paddr == `IRQCMD_OFS_MASK) begin
			mask <= pwdata[3:0];
		end
	end

	// Level interrupt; lags the status bits by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt & mask);
		end
	end

	// Read data and error answer are latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `IRQCMD_ZERO32;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= 1'b0;
			prdata <= `IRQCMD_ZERO32;
			if (setup) begin
				case (paddr)
					`IRQCMD_OFS_HEAD: prdata <= head;
					`IRQCMD_OFS_VALUE: prdata <= value;
					`IRQCMD_OFS_CHECK: prdata <= {24'h0, sum};
					`IRQCMD_OFS_REPLY: prdata <= {24'h0, reply_st};
					`IRQCMD_OFS_RVAL: prdata <= reply_val;
					`IRQCMD_OFS_ERR: prdata <= {27'h0, err_flags};
					`IRQCMD_OFS_IEN: prdata <= {15'h0, irq_global, irq_enable};
					`IRQCMD_OFS_EVT: prdata <= {28'h0, evt};
					`IRQCMD_OFS_MASK: prdata <= {28'h0, mask};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Checks next to the logic they guard
	a_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex_ok && ex.instr == `IRQCMD_OP_CLEAR
		&& ex.typ == 8'h00 && err_s2 == 5'h00
		|=> err_flags == 5'h00)
		else $error("clear all left a flag set");
	a_clear_one: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex_ok && ex.instr == `IRQCMD_OP_CLEAR
		&& ex.typ == 8'h03 && err_s2 == 5'h00
		|=> !err_flags[2] && err_flags[4:3] == $past(err_flags[4:3])
		&& err_flags[1:0] == $past(err_flags[1:0]))
		else $error("single clear touched the wrong flag");
	a_clear_only: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex.instr != `IRQCMD_OP_CLEAR && err_s2 == 5'h00
		|=> err_flags == $past(err_flags))
		else $error("flags changed without a clear");
	a_unmask_glob: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex_ok && ex.instr == `IRQCMD_OP_UNMASK
		&& ex.typ == 8'hFF |=> irq_global
		&& irq_enable == $past(irq_enable))
		else $error("global enable not set");
	a_maskoff_glob: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex_ok && ex.instr == `IRQCMD_OP_MASKOFF
		&& ex.typ == 8'hFF |=> !irq_global)
		else $error("global enable not cleared");
	a_unmask_one: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex_ok && ex.instr == `IRQCMD_OP_UNMASK
		&& idx_ok |=> irq_enable[$past(ex.typ[3:0])])
		else $error("single enable missed");
	a_maskoff_one: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex_ok && ex.instr == `IRQCMD_OP_MASKOFF
		&& idx_ok |=> !irq_enable[$past(ex.typ[3:0])])
		else $error("single disable missed");
	a_vec_host: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex_host && ex_ok && ex.instr == `IRQCMD_OP_VECSET
		|=> !vec_we && reply_st == 8'h06)
		else $error("host handler address not refused");
	a_vec_store: assert property (@(posedge pclk) disable iff (!presetn)
		vec_we && vec_rd_idx == vec_waddr ##1 vec_rd_idx == $past(vec_rd_idx)
		|=> vec_rd_data == $past(vec_wdata, 2))
		else $error("handler address not stored");
	a_return_ctx: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && !ex_host && ex.instr == `IRQCMD_OP_RETURN && !ctx_save
		|=> ctx_restore && ctx_out == $past(saved))
		else $error("return did not restore context");
	a_uf_slot: assert property (@(posedge pclk) disable iff (!presetn)
		ex_valid && ex_ok && ex.instr == `IRQCMD_OP_UF_HI |=> uf_start
		&& uf_slot == 3'h7
		##1 !uf_start || $past(ex_valid && is_uf))
		else $error("user slot not started");
	a_csum_bad: assert property (@(posedge pclk) disable iff (!presetn)
		wr_check && sum != pwdata[7:0]
		|=> ##1 reply_st == 8'h01 && !uf_start)
		else $error("bad checksum accepted");
	c_host_frame: cover property (@(posedge pclk) disable iff (!presetn)
		host_pend && csum_ok);
	c_prog_vec: cover property (@(posedge pclk) disable iff (!presetn)
		vec_we);
	c_return: cover property (@(posedge pclk) disable iff (!presetn)
		ctx_restore);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule : irqcmd_top
`default_nettype wire

// File: irqcmd_map.svh
// Register offsets, field positions, codes and reset values for irqcmd
`ifndef IRQCMD_MAP_SVH
`define IRQCMD_MAP_SVH
`define IRQCMD_OFS_HEAD 8'h00
`define IRQCMD_OFS_VALUE 8'h04
`define IRQCMD_OFS_CHECK 8'h08
`define IRQCMD_OFS_REPLY 8'h0C
`define IRQCMD_OFS_RVAL 8'h10
`define IRQCMD_OFS_ERR 8'h14
`define IRQCMD_OFS_IEN 8'h18
`define IRQCMD_OFS_EVT 8'h1C
`define IRQCMD_OFS_MASK 8'h20
`define IRQCMD_OP_CLEAR 8'h24
`define IRQCMD_OP_UNMASK 8'h19
`define IRQCMD_OP_MASKOFF 8'h1A
`define IRQCMD_OP_VECSET 8'h25
`define IRQCMD_OP_RETURN 8'h26
`define IRQCMD_OP_UF_LO 8'h40
`define IRQCMD_OP_UF_HI 8'h47
`define IRQCMD_TYPE_ALL 8'h00
`define IRQCMD_TYPE_GLOBAL 8'hFF
`define IRQCMD_NERR 5
`define IRQCMD_NIRQ 16
`define IRQCMD_NEVT 4
`define IRQCMD_EVT_DONE 0
`define IRQCMD_EVT_CSUM 1
`define IRQCMD_EVT_REFUSE 2
`define IRQCMD_EVT_ERR 3
`define IRQCMD_ST_OK 8'h64
`define IRQCMD_ST_CSUM 8'h01
`define IRQCMD_ST_BADCMD 8'h02
`define IRQCMD_ST_BADTYPE 8'h03
`define IRQCMD_ST_REFUSED 8'h06
`define IRQCMD_ZERO32 32'h0000_0000
`endif

// File: irqcmd_pkg.sv
// Types shared by the irqcmd command block
package irqcmd_pkg;
	typedef struct packed {
		logic [7:0] instr;
		logic [7:0] typ;
		logic [7:0] bank;
		logic [31:0] value;
	} irqcmd_cmd_t;
	typedef struct packed {
		logic [31:0] acc;
		logic [31:0] x;
		logic [7:0] flags;
		logic [31:0] pc;
	} irqcmd_ctx_t;
endpackage : irqcmd_pkg

// File: irqcmd_vec_mem.sv
// Handler address table with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module irqcmd_vec_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];

	// Later writes simply overwrite the slot
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : irqcmd_vec_mem
`default_nettype wire

// File: irqcmd_prog_model.sv
// Stored-program side model: issues program commands and handler context
`timescale 1ns/1ps
`default_nettype none
module irqcmd_prog_model (
	input wire logic pclk,
	input wire logic prog_ready,
	output logic prog_valid,
	output irqcmd_pkg::irqcmd_cmd_t prog_cmd,
	output logic ctx_save,
	output irqcmd_pkg::irqcmd_ctx_t ctx_in
);
	// Idle bus starts all ones and later holds the inverted last command, so a stale command is never mistaken for a new one
	initial begin
		prog_valid = 1'b0;
		prog_cmd = '1;
		ctx_save = 1'b0;
		ctx_in = '0;
	end
	// One command from the stored program, held until it is taken
	task automatic issue(input logic [7:0] op, input logic [7:0] t,
		input logic [31:0] v);
		@(posedge pclk);
		prog_valid <= 1'b1;
		prog_cmd <= {op, t, 8'h00, v};
		// Only the bench watchdog ends a wait that never gets an answer
		do begin
			@(posedge pclk);
		end while (prog_ready !== 1'b1);
		prog_valid <= 1'b0;
		prog_cmd <= ~{op, t, 8'h00, v};
	endtask : issue
	// Handler entry saves context; the handler is always closed by a return
	task automatic enter(input irqcmd_pkg::irqcmd_ctx_t c);
		@(posedge pclk);
		ctx_save <= 1'b1;
		ctx_in <= c;
		@(posedge pclk);
		ctx_save <= 1'b0;
		ctx_in <= ~c;
		issue(8'h26, 8'hFF, 32'h0000_0000);
	endtask : enter
endmodule : irqcmd_prog_model
`default_nettype wire

// File: test_irq_and_error_flag_cmds.sv
// Testbench for the interrupt and error-flag command block
`timescale 1ns/1ps
`default_nettype none
`include "irqcmd_map.svh"
module test_irq_and_error_flag_cmds;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, prog_valid;
	logic prog_ready, ctx_save, ctx_restore, irq_global, uf_start, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, vec_rd_data, uf_reply, rd;
	logic [4:0] err_pin, err_flags;
	logic [15:0] irq_enable;
	logic [3:0] vec_rd_idx;
	logic [2:0] uf_slot;
	logic se;
	irqcmd_pkg::irqcmd_cmd_t prog_cmd, uf_cmd;
	irqcmd_pkg::irqcmd_ctx_t ctx_in, ctx_out, ctx;
	int err_count = 0;
	int n_tests = 0;
	// Clock at 200 MHz
	always #2.5 pclk = ~pclk;
	irqcmd_top irqcmd_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .prog_valid, .prog_cmd,
		.prog_ready, .ctx_save, .ctx_in, .ctx_restore, .ctx_out, .err_pin,
		.err_flags, .irq_enable, .irq_global, .vec_rd_idx, .vec_rd_data,
		.uf_start, .uf_slot, .uf_cmd, .uf_reply, .irq);
	irqcmd_prog_model irqcmd_prog_model_i (.pclk, .prog_ready, .prog_valid,
		.prog_cmd, .ctx_save, .ctx_in);
	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// One APB transfer, held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Host frame; bad skews the checksum, bank and value are noise
	task automatic frame(input logic [7:0] op, input logic [7:0] t,
		input logic [31:0] v, input logic [7:0] bad);
		logic [7:0] s;
		s = 8'h01 + op + t + 8'hA5 + v[31:24] + v[23:16] + v[15:8] + v[7:0];
		apb(1'b1, `IRQCMD_OFS_HEAD, {8'h01, op, t, 8'hA5});
		apb(1'b1, `IRQCMD_OFS_VALUE, v);
		apb(1'b1, `IRQCMD_OFS_CHECK, {24'h000000, s + bad});
		repeat (4) @(posedge pclk);
	endtask : frame
	task automatic reply(input logic [7:0] st);
		apb(1'b0, `IRQCMD_OFS_REPLY, 32'h0000_0000);
		chk(rd & 32'h0000_00FF, {24'h000000, st});
	endtask : reply
	task automatic ien(input logic [7:0] op, input logic [7:0] t,
		input logic [31:0] e);
		frame(op, t, 32'hDEAD_0001, 8'h00);
		apb(1'b0, `IRQCMD_OFS_IEN, 32'h0000_0000);
		chk(rd, e);
		chk({15'h0, irq_global, irq_enable}, e);
	endtask : ien
	// Watchdog sized well above the whole sequence
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		test_done;
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		err_pin = 5'h00;
		vec_rd_idx = 4'h2;
		uf_reply = 32'h0000_A5C3;
		ctx = {32'h1111_2222, 32'h3333_4444, 8'h5A, 32'h0000_0123};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `IRQCMD_OFS_IEN, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		chk({31'h0, se}, 32'h1);
		// Raise all error pins, then clear by every type
		for (int t = 0; t <= 5; t++) begin
			err_pin <= 5'h1F;
			repeat (4) @(posedge pclk);
			err_pin <= 5'h00;
			repeat (4) @(posedge pclk);
			frame(`IRQCMD_OP_CLEAR, t[7:0], 32'h1234_5678, 8'h00);
			apb(1'b0, `IRQCMD_OFS_ERR, 32'h0000_0000);
			chk(rd, t == 0 ? 32'h0 : 32'h1F & ~(32'h1 << (t - 1)));
			chk({27'h0, err_flags}, rd);
			reply(`IRQCMD_ST_OK);
		end
		frame(`IRQCMD_OP_CLEAR, 8'h06, 32'h0000_0000, 8'h00);
		reply(`IRQCMD_ST_BADTYPE);
		ien(`IRQCMD_OP_UNMASK, 8'h03, 32'h0000_0008);
		ien(`IRQCMD_OP_UNMASK, 8'hFF, 32'h0001_0008);
		ien(`IRQCMD_OP_MASKOFF, 8'h03, 32'h0001_0000);
		ien(`IRQCMD_OP_MASKOFF, 8'hFF, 32'h0000_0000);
		// Handler table written from the program, then a host attempt
		irqcmd_prog_model_i.issue(`IRQCMD_OP_VECSET, 8'h02, 32'h0000_0032);
		repeat (3) @(posedge pclk);
		chk(vec_rd_data, 32'h0000_0032);
		irqcmd_prog_model_i.issue(`IRQCMD_OP_VECSET, 8'h02, 32'h0000_0077);
		repeat (3) @(posedge pclk);
		chk(vec_rd_data, 32'h0000_0077);
		frame(`IRQCMD_OP_VECSET, 8'h02, 32'h0000_0099, 8'h00);
		reply(`IRQCMD_ST_REFUSED);
		chk(vec_rd_data, 32'h0000_0077);
		frame(`IRQCMD_OP_RETURN, 8'hFF, 32'h0000_0000, 8'h00);
		reply(`IRQCMD_ST_REFUSED);
		// Highest user slot from the host, lowest from the program
		frame(`IRQCMD_OP_UF_HI, 8'h11, 32'h0000_0001, 8'h00);
		reply(`IRQCMD_ST_OK);
		apb(1'b0, `IRQCMD_OFS_RVAL, 32'h0000_0000);
		chk(rd, 32'h0000_A5C3);
		irqcmd_prog_model_i.issue(`IRQCMD_OP_UF_LO, 8'h03, 32'h0000_5A5A);
		#1;
		chk({29'h0, uf_slot}, 32'h0);
		chk({31'h0, uf_start}, 32'h1);
		chk(uf_cmd.value, 32'h0000_5A5A);
		chk({16'h0, uf_cmd.instr, uf_cmd.typ}, 32'h0000_4003);
		irqcmd_prog_model_i.enter(ctx);
		#1;
		chk({31'h0, ctx_restore}, 32'h1);
		chk({31'h0, ctx_out === ctx}, 32'h1);
		// Bad checksum has no effect; events stay quiet while masked
		frame(`IRQCMD_OP_UNMASK, 8'h05, 32'h0000_0000, 8'h01);
		apb(1'b0, `IRQCMD_OFS_IEN, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		reply(`IRQCMD_ST_CSUM);
		frame(8'h27, 8'h00, 32'h0000_0000, 8'h00);
		reply(`IRQCMD_ST_BADCMD);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `IRQCMD_OFS_MASK, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, `IRQCMD_OFS_EVT, 32'h0000_0000);
		chk(rd & 32'h0000_0002, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		test_done;
	end
endmodule : test_irq_and_error_flag_cmds
`default_nettype wire
